// File: logic/acr_regs.sv
// channel config register bank with Avalon-MM slave and spare pin output
`timescale 1ns/1ps
`include "acr_defs.svh"

module acr_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic [1:0]             avs_response,
   output logic                   avs_waitrequest,
   input  wire logic              mod_tick,
   input  wire logic              conv_start,
   output acr_pkg::acr_ctl_t      ctl,
   output logic [1:0][7:0]        gain_factor,
   output logic [3:0]             ch0_route,
   output logic                   spare_pin_digital_output,
   output logic                   spare_pin_oe,
   output logic                   settle_busy,
   output logic                   meas_start
);

   // byte lane merge; read-only bits always come back as zero
   function automatic logic [15:0] lane_merge(
      input logic [15:0] old_v,
      input logic [15:0] wd,
      input logic [1:0]  be,
      input logic [15:0] ro_mask
   );
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      lane_merge = ((old_v & ~m) | (wd & m)) & ~ro_mask;
   endfunction : lane_merge

   // word aligned and one of the mapped indices
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [`ACR_IDX_W-1:0] i;
      i = a[`ACR_IDX_W+1:2];
      addr_hit = 1'b0;
      if (a[1:0] != 2'h0)
      begin
         addr_hit = 1'b0;
      end
      else if (i == `ACR_IDX_GAIN)
      begin
         addr_hit = 1'b1;
      end
      else if (i == `ACR_IDX_GCFG)
      begin
         addr_hit = 1'b1;
      end
      else if (i == `ACR_IDX_STAT)
      begin
         addr_hit = 1'b1;
      end
      else if (i == `ACR_IDX_CH0CFG)
      begin
         addr_hit = 1'b1;
      end
      else if (i == `ACR_IDX_OCALU)
      begin
         addr_hit = 1'b1;
      end
      else if (i == `ACR_IDX_OCALL)
      begin
         addr_hit = 1'b1;
      end
   endfunction : addr_hit

   // power of two gain from a three bit code
   function automatic logic [7:0] gain_of(input logic [2:0] code);
      gain_of = 8'h01 << code;
   endfunction : gain_of

   acr_pkg::acr_bus_st_t   bus_st_r;
   acr_pkg::acr_bus_st_t   bus_st_nxt;
   logic [31:0]            rdata_r;
   logic [31:0]            rdata_nxt;
   logic [1:0]             resp_r;
   logic [1:0]             resp_nxt;

   logic [15:0]            gain_r;
   logic [15:0]            gain_nxt;
   logic [15:0]            gcfg_r;
   logic [15:0]            gcfg_nxt;
   logic [15:0]            ch0cfg_r;
   logic [15:0]            ch0cfg_nxt;
   logic [15:0]            ocalu_r;
   logic [15:0]            ocalu_nxt;
   logic [15:0]            ocall_r;
   logic [15:0]            ocall_nxt;

   logic [`ACR_IDX_W-1:0]  idx;
   logic                   req;
   logic                   hit;
   logic                   wr_commit;
   logic [15:0]            stat_v;
   logic [15:0]            rd_v;
   logic [15:0]            wd;
   logic [1:0]             be;

   assign idx = avs_address[`ACR_IDX_W+1:2];
   assign req = avs_read | avs_write;
   assign hit = addr_hit(avs_address);
   assign wd = avs_writedata[15:0];
   assign be = avs_byteenable[1:0];

   // one wait state: request seen, answered on the following edge
   assign avs_waitrequest = req & (bus_st_r != acr_pkg::ACR_BUS_ACK);
   assign wr_commit = avs_write & hit & (bus_st_r == acr_pkg::ACR_BUS_ACK);

   assign stat_v = {15'h0000, settle_busy};

   always_comb
   begin
      rd_v = 16'h0000;
      if (!hit)
      begin
         rd_v = 16'h0000;
      end
      else if (idx == `ACR_IDX_GAIN)
      begin
         rd_v = gain_r;
      end
      else if (idx == `ACR_IDX_GCFG)
      begin
         rd_v = gcfg_r;
      end
      else if (idx == `ACR_IDX_STAT)
      begin
         rd_v = stat_v;
      end
      else if (idx == `ACR_IDX_CH0CFG)
      begin
         rd_v = ch0cfg_r & ~`ACR_RO_CH0CFG; // see (R8)
      end
      else if (idx == `ACR_IDX_OCALU)
      begin
         rd_v = ocalu_r;
      end
      else if (idx == `ACR_IDX_OCALL)
      begin
         rd_v = ocall_r & ~`ACR_RO_OCALL; // see (R13)
      end
   end

   always_comb
   begin
      bus_st_nxt = bus_st_r;
      rdata_nxt = rdata_r;
      resp_nxt = resp_r;
      case (bus_st_r)
         acr_pkg::ACR_BUS_IDLE:
         begin
            if (req)
            begin
               bus_st_nxt = acr_pkg::ACR_BUS_ACK;
               rdata_nxt = avs_read ? {16'h0000, rd_v} : 32'h00000000;
               resp_nxt = hit ? `ACR_RESP_OK : `ACR_RESP_ERR;
            end
         end
         acr_pkg::ACR_BUS_ACK:
         begin
            bus_st_nxt = acr_pkg::ACR_BUS_IDLE;
         end
         default:
         begin
            bus_st_nxt = acr_pkg::ACR_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus_st_r <= acr_pkg::ACR_BUS_IDLE;
         rdata_r <= 32'h00000000;
         resp_r <= `ACR_RESP_OK;
      end
      else
      begin
         bus_st_r <= bus_st_nxt;
         rdata_r <= rdata_nxt;
         resp_r <= resp_nxt;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_response = resp_r;

   // reserved bits of the gain and general config words are stored as written;
   // software is trusted to keep them zero, the logic never reads them
   always_comb
   begin
      gain_nxt = gain_r;
      gcfg_nxt = gcfg_r;
      ch0cfg_nxt = ch0cfg_r;
      ocalu_nxt = ocalu_r;
      ocall_nxt = ocall_r;
      if (wr_commit)
      begin
         if (idx == `ACR_IDX_GAIN)
         begin
            gain_nxt = lane_merge(gain_r, wd, be, `ACR_RO_NONE); // see (R3)
         end
         else if (idx == `ACR_IDX_GCFG)
         begin
            gcfg_nxt = lane_merge(gcfg_r, wd, be, `ACR_RO_NONE); // see (R3)
         end
         else if (idx == `ACR_IDX_CH0CFG)
         begin
            ch0cfg_nxt = lane_merge(ch0cfg_r, wd, be,
                                    `ACR_RO_CH0CFG); // see (R8)
         end
         else if (idx == `ACR_IDX_OCALU)
         begin
            ocalu_nxt = lane_merge(ocalu_r, wd, be,
                                   `ACR_RO_NONE); // see (R11)
         end
         else if (idx == `ACR_IDX_OCALL)
         begin
            ocall_nxt = lane_merge(ocall_r, wd, be,
                                   `ACR_RO_OCALL); // see (R13)
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gain_r <= `ACR_RST_GAIN;
         gcfg_r <= `ACR_RST_GCFG; // see (R7)
         ch0cfg_r <= `ACR_RST_CH0CFG; // see (R10)
         ocalu_r <= `ACR_RST_OCALU; // see (R11)
         ocall_r <= `ACR_RST_OCALL; // see (R12)
      end
      else
      begin
         gain_r <= gain_nxt;
         gcfg_r <= gcfg_nxt;
         ch0cfg_r <= ch0cfg_nxt;
         ocalu_r <= ocalu_nxt;
         ocall_r <= ocall_nxt;
      end
   end

   // field views of the stored words
   always_comb
   begin
      ctl = '0;
      ctl.ch1_gain_code =
         gain_r[`ACR_CH1_GAIN_HI:`ACR_CH1_GAIN_LO]; // see (R1)
      ctl.ch0_gain_code =
         gain_r[`ACR_CH0_GAIN_HI:`ACR_CH0_GAIN_LO]; // see (R2)
      ctl.spare_pin_output_enable = gcfg_r[`ACR_SPARE_OE_BIT]; // see (R4)
      ctl.spare_pin_output_level = gcfg_r[`ACR_SPARE_LVL_BIT]; // see (R5)
      ctl.chop_settle_delay_code =
         gcfg_r[`ACR_CHOP_DLY_HI:`ACR_CHOP_DLY_LO]; // see (R6)
      ctl.chop_enable = gcfg_r[`ACR_CHOP_EN_BIT]; // see (R6)
      ctl.ch0_phase_delay =
         signed'(ch0cfg_r[`ACR_PHASE_HI:`ACR_PHASE_LO]); // see (R8)
      ctl.ch0_input_select =
         acr_pkg::acr_mux_t'(ch0cfg_r[`ACR_SEL_HI:`ACR_SEL_LO]); // see (R9)
      ctl.ch0_offset =
         {ocalu_r, ocall_r[`ACR_OCALL_HI:`ACR_OCALL_LO]}; // see (R11)
   end

   // gain factor per channel, index 0 is channel 0
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_gain
         if (g == 0)
         begin : g_c0
            assign gain_factor[g] = gain_of(ctl.ch0_gain_code); // see (R2)
         end
         else
         begin : g_c1
            assign gain_factor[g] = gain_of(ctl.ch1_gain_code); // see (R1)
         end
      end
   endgenerate

   // one-hot input routing: normal, shorted, dc diag, ac diag
   always_comb
   begin
      ch0_route = 4'h0;
      case (ctl.ch0_input_select)
         acr_pkg::ACR_MUX_NORMAL:  ch0_route = 4'h1; // see (R9)
         acr_pkg::ACR_MUX_SHORTED: ch0_route = 4'h2; // see (R9)
         acr_pkg::ACR_MUX_DC_DIAG: ch0_route = 4'h4; // see (R9)
         acr_pkg::ACR_MUX_AC_DIAG: ch0_route = 4'h8; // see (R9)
         default:                  ch0_route = 4'h1;
      endcase
   end

   // pin released while disabled, level parked low to avoid glitches
   assign spare_pin_oe = ctl.spare_pin_output_enable; // see (R4)
   assign spare_pin_digital_output =
      ctl.spare_pin_output_enable & ctl.spare_pin_output_level; // see (R5)

   acr_chop_timer #(
      .CNT_W       (17)
   ) u_chop (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .chop_enable (ctl.chop_enable),
      .delay_code  (ctl.chop_settle_delay_code),
      .mod_tick    (mod_tick),
      .conv_start  (conv_start),
      .settle_busy (settle_busy),
      .meas_start  (meas_start)
   );

endmodule : acr_regs

// File: logic/acr_defs.svh
// register offsets, field positions and reset values of the config bank
//
// Contract
// (R1) ch1 gain bits 6:4, gain two to code
// (R2) ch0 gain bits 2:0, same doubling encoding
// (R3) host writes zeros into reserved bit positions
// (R4) bit 14 turns spare analog pin into output
// (R5) bit 13 sets spare pin level while enabled
// (R6) chop bit 8, settle wait 2 shl code
// (R7) general config at 06h, resets to 0600h
// (R8) ch0 phase signed 10 bits, bits 5:2 zero
// (R9) ch0 input selector routes four input sources
// (R10) ch0 config at 09h, resets to zero
// (R11) upper offset word 0Ah holds offset 23:8
// (R12) lower offset word at 0Bh, resets zero
// (R13) lower word bits 15:8 offset, 7:0 zero
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

`define ACR_IDX_W            6
`define ACR_IDX_GAIN         6'h04
`define ACR_IDX_GCFG         6'h06
`define ACR_IDX_STAT         6'h07
`define ACR_IDX_CH0CFG       6'h09
`define ACR_IDX_OCALU        6'h0A
`define ACR_IDX_OCALL        6'h0B

`define ACR_RST_GAIN         16'h0000
`define ACR_RST_GCFG         16'h0600
`define ACR_RST_CH0CFG       16'h0000
`define ACR_RST_OCALU        16'h0000
`define ACR_RST_OCALL        16'h0000

`define ACR_CH1_GAIN_HI      6
`define ACR_CH1_GAIN_LO      4
`define ACR_CH0_GAIN_HI      2
`define ACR_CH0_GAIN_LO      0
`define ACR_SPARE_OE_BIT     14
`define ACR_SPARE_LVL_BIT    13
`define ACR_CHOP_DLY_HI      12
`define ACR_CHOP_DLY_LO      9
`define ACR_CHOP_EN_BIT      8
`define ACR_PHASE_HI         15
`define ACR_PHASE_LO         6
`define ACR_SEL_HI           1
`define ACR_SEL_LO           0
`define ACR_OCALL_HI         15
`define ACR_OCALL_LO         8
`define ACR_STAT_BUSY_BIT    0

`define ACR_RO_CH0CFG        16'h003C
`define ACR_RO_OCALL         16'h00FF
`define ACR_RO_NONE          16'h0000

`define ACR_RESP_OK          2'h0
`define ACR_RESP_ERR         2'h2

`define ACR_CHOP_BASE        17'h00002

`endif

// File: logic/acr_pkg.sv
// types shared by the config bank and its chop settle timer
package acr_pkg;

   typedef enum logic [1:0]
   {
      ACR_MUX_NORMAL,
      ACR_MUX_SHORTED,
      ACR_MUX_DC_DIAG,
      ACR_MUX_AC_DIAG
   } acr_mux_t;

   typedef enum logic
   {
      ACR_BUS_IDLE,
      ACR_BUS_ACK
   } acr_bus_st_t;

   typedef enum logic
   {
      ACR_TMR_IDLE,
      ACR_TMR_SETTLE
   } acr_tmr_st_t;

   typedef struct packed {
      logic [2:0]        ch1_gain_code;
      logic [2:0]        ch0_gain_code;
      logic              spare_pin_output_enable;
      logic              spare_pin_output_level;
      logic [3:0]        chop_settle_delay_code;
      logic              chop_enable;
      logic signed [9:0] ch0_phase_delay;
      acr_mux_t          ch0_input_select;
      logic [23:0]       ch0_offset;
   } acr_ctl_t;

endpackage : acr_pkg

// File: logic/acr_chop_timer.sv
// global chop settle timer counted in modulator clock periods
`timescale 1ns/1ps
`include "acr_defs.svh"

module acr_chop_timer #(
   parameter int CNT_W = 17
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       chop_enable,
   input  wire logic [3:0] delay_code,
   input  wire logic       mod_tick,
   input  wire logic       conv_start,
   output logic            settle_busy,
   output logic            meas_start
);

   // wait length doubles per code, 2 up to 65536
   function automatic logic [CNT_W-1:0] settle_len(input logic [3:0] c);
      settle_len = CNT_W'(`ACR_CHOP_BASE) << c;
   endfunction : settle_len

   acr_pkg::acr_tmr_st_t   st_r;
   acr_pkg::acr_tmr_st_t   st_nxt;
   logic [CNT_W-1:0]       cnt_r;
   logic [CNT_W-1:0]       cnt_nxt;
   logic [CNT_W-1:0]       len_r;
   logic [CNT_W-1:0]       len_nxt;
   logic                   go_r;
   logic                   go_nxt;

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      len_nxt = len_r;
      go_nxt = 1'b0;
      case (st_r)
         acr_pkg::ACR_TMR_IDLE:
         begin
            if (conv_start && chop_enable)
            begin
               st_nxt = acr_pkg::ACR_TMR_SETTLE; // see (R6)
               cnt_nxt = '0;
               len_nxt = settle_len(delay_code); // see (R6)
            end
            else if (conv_start)
            begin
               go_nxt = 1'b1;
            end
         end
         acr_pkg::ACR_TMR_SETTLE:
         begin
            // a new start restarts the wait from zero
            if (conv_start)
            begin
               cnt_nxt = '0;
               len_nxt = settle_len(delay_code);
            end
            else if (mod_tick)
            begin
               cnt_nxt = cnt_r + CNT_W'(1);
               if (cnt_nxt == len_r)
               begin
                  st_nxt = acr_pkg::ACR_TMR_IDLE; // see (R6)
                  go_nxt = 1'b1;
               end
            end
         end
         default:
         begin
            st_nxt = acr_pkg::ACR_TMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= acr_pkg::ACR_TMR_IDLE;
         cnt_r <= '0;
         len_r <= '0;
         go_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         len_r <= len_nxt;
         go_r <= go_nxt;
      end
   end

   assign settle_busy = (st_r == acr_pkg::ACR_TMR_SETTLE);
   assign meas_start = go_r;

endmodule : acr_chop_timer

// File: dv/acr_regs_assertions.sv
// concurrent checks on the config bank ports
`timescale 1ns/1ps

module acr_regs_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              conv_start,
   input wire acr_pkg::acr_ctl_t ctl,
   input wire logic [1:0][7:0]   gain_factor,
   input wire logic [3:0]        ch0_route,
   input wire logic              spare_pin_digital_output,
   input wire logic              spare_pin_oe,
   input wire logic              settle_busy,
   input wire logic              meas_start
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_rd_done(a);
      avs_read && !avs_waitrequest && avs_address == a;
   endsequence
   sequence s_chop_go;
      conv_start && ctl.chop_enable;
   endsequence

   property p_gain0;
      gain_factor[0] == (8'h01 << ctl.ch0_gain_code);
   endproperty
   a_gain0: assert property (p_gain0)
      else $error("ch0 gain factor wrong");
   property p_gain1;
      gain_factor[1] == (8'h01 << ctl.ch1_gain_code);
   endproperty
   a_gain1: assert property (p_gain1)
      else $error("ch1 gain factor wrong");
   property p_spare_oe;
      spare_pin_oe == ctl.spare_pin_output_enable;
   endproperty
   a_spare_oe: assert property (p_spare_oe)
      else $error("spare pin enable wrong");
   property p_spare_lvl;
      spare_pin_digital_output ==
         (ctl.spare_pin_output_enable && ctl.spare_pin_output_level);
   endproperty
   a_spare_lvl: assert property (p_spare_lvl)
      else $error("spare pin level wrong");
   property p_route;
      ch0_route == (4'h1 << ctl.ch0_input_select);
   endproperty
   a_route: assert property (p_route)
      else $error("ch0 route wrong");
   property p_cfg_ro;
      s_rd_done(8'h24) |-> avs_readdata[5:2] == 4'h0;
   endproperty
   a_cfg_ro: assert property (p_cfg_ro)
      else $error("channel0_config reserved bits not zero");
   property p_low_ro;
      s_rd_done(8'h2C) |-> avs_readdata[7:0] == 8'h00;
   endproperty
   a_low_ro: assert property (p_low_ro)
      else $error("lower offset low byte not zero");
   property p_reset_val;
      $rose(rst_b) |-> ctl.chop_settle_delay_code == 4'h3 &&
         !ctl.chop_enable && ctl.ch0_offset == 24'h000000;
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("reset values wrong");
   property p_chop_go;
      s_chop_go |=> settle_busy && !meas_start;
   endproperty
   a_chop_go: assert property (p_chop_go)
      else $error("settle wait not started");
   property p_chop_end;
      $fell(settle_busy) |-> meas_start;
   endproperty
   a_chop_end: assert property (p_chop_end)
      else $error("measurement start missing");
endmodule : acr_regs_chk

bind acr_regs acr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .rst_b,
   .avs_address, .avs_read, .avs_readdata, .avs_waitrequest, .conv_start,
   .ctl, .gain_factor, .ch0_route, .spare_pin_digital_output,
   .spare_pin_oe, .settle_busy, .meas_start);

// File: dv/acr_tb.sv
// self-checking bench for the config bank
`timescale 1ns/1ps

module tb;
   logic              ref_clk = 1'b0;
   logic              rst_b = 1'b0;
   logic [7:0]        avs_address = 8'h00;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [31:0]       avs_writedata = 32'h0;
   logic [31:0]       avs_readdata;
   logic [1:0]        avs_response;
   logic              avs_waitrequest;
   logic              conv_start = 1'b0;
   logic              mod_tick = 1'b1;
   logic              tick_half = 1'b0;
   acr_pkg::acr_ctl_t ctl;
   logic [1:0][7:0]   gain_factor;
   logic [3:0]        ch0_route;
   logic              spare_pin_digital_output;
   logic              spare_pin_oe;
   logic              settle_busy;
   logic              meas_start;
   logic [31:0]       rd;
   logic [1:0]        rsp;
   int                error_cnt = 0;
   int                check_count = 0;

   always #4 ref_clk = ~ref_clk;

   // tick every cycle keeps settle waits short; half rate proves it is used
   always @(posedge ref_clk)
      mod_tick <= tick_half ? !mod_tick : 1'b1;

   acr_regs #(.ADDR_W(8)) dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_response(avs_response),
      .avs_waitrequest(avs_waitrequest), .mod_tick(mod_tick),
      .conv_start(conv_start), .ctl(ctl), .gain_factor(gain_factor),
      .ch0_route(ch0_route),
      .spare_pin_digital_output(spare_pin_digital_output),
      .spare_pin_oe(spare_pin_oe), .settle_busy(settle_busy),
      .meas_start(meas_start));

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [15:0] d);
      logic w;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge ref_clk);
         w = avs_waitrequest;
         rd = avs_readdata;
         rsp = avs_response;
      end
      while (w);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
      @(negedge ref_clk);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 16'h0000);
      check(rd, exp);
      check({30'h0, rsp}, 32'h0);
   endtask : rdchk

   task automatic chop(input logic [15:0] cfg, input logic half,
                       input int exp);
      int n;
      wr(8'h18, cfg);
      @(posedge ref_clk);
      conv_start <= 1'b1;
      tick_half <= half;
      @(posedge ref_clk);
      conv_start <= 1'b0;
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (meas_start !== 1'b1 && n < 100);
      tick_half <= 1'b0;
      check(32'(n), 32'(exp));
   endtask : chop

   initial
   begin
      #100000;
      error_cnt++;
      test_done();
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdchk(8'h18, 32'h0600);
      rdchk(8'h24, 32'h0);
      rdchk(8'h28, 32'h0);
      rdchk(8'h2C, 32'h0);
      rdchk(8'h10, 32'h0);
      $display("reset test done");
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h10, {9'h000, c[2:0], 1'b0, c[2:0]});
         check(gain_factor[0], 32'h1 << c);
         check(gain_factor[1], 32'h1 << c);
      end
      wr(8'h10, 16'h0025);
      check(gain_factor, 32'h0420);
      rdchk(8'h10, 32'h0025);
      $display("gain test done");
      wr(8'h18, 16'h2600);
      check({spare_pin_oe, spare_pin_digital_output}, 32'h0);
      wr(8'h18, 16'h6600);
      check({spare_pin_oe, spare_pin_digital_output}, 32'h3);
      wr(8'h18, 16'h4600);
      check({spare_pin_oe, spare_pin_digital_output}, 32'h2);
      $display("spare pin test done");
      wr(8'h24, 16'hFFFF);
      rdchk(8'h24, 32'hFFC3);
      check({22'h0, ctl.ch0_phase_delay}, 32'h3FF);
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h24, {14'h2000, m[1:0]});
         check(ch0_route, 32'h1 << m);
      end
      check({22'h0, ctl.ch0_phase_delay}, 32'h200);
      $display("channel config test done");
      wr(8'h28, 16'h1234);
      wr(8'h2C, 16'hABCD);
      rdchk(8'h2C, 32'hAB00);
      rdchk(8'h28, 32'h1234);
      check({8'h0, ctl.ch0_offset}, 32'h1234AB);
      // unmapped place answers with slave error and zero data
      bus(1'b0, 8'h3C, 16'h0000);
      check(rd, 32'h0);
      check({30'h0, rsp}, 32'h2);
      $display("offset test done");
      chop(16'h0000, 1'b0, 1);
      chop(16'h0100, 1'b0, 3);
      chop(16'h0300, 1'b0, 5);
      chop(16'h0700, 1'b0, 17);
      chop(16'h0100, 1'b1, 5);
      $display("chop test done");
      // reset in mid wait clears the bank and the timer
      wr(8'h18, 16'h0700);
      @(posedge ref_clk);
      conv_start <= 1'b1;
      @(posedge ref_clk);
      conv_start <= 1'b0;
      rdchk(8'h1C, 32'h1);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdchk(8'h1C, 32'h0);
      rdchk(8'h18, 32'h0600);
      rdchk(8'h24, 32'h0);
      rdchk(8'h2C, 32'h0);
      $display("mid-run reset test done");
      test_done();
   end
endmodule : tb
